// [rtl/pwm_single_consts.vh]
/*
  constants for the single 8-bit pwm block: register byte offsets, control field
  positions, reset values and interrupt bit layout. assumes byte addresses on a
  32-bit axi4-lite bus, one aligned word per register.
*/
`ifndef PWM_SINGLE_CONSTS_VH
`define PWM_SINGLE_CONSTS_VH

`define OFS_CONTROL 8'h00
`define OFS_PERIOD 8'h04
`define OFS_DUTY 8'h08
`define OFS_COUNT 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14

`define BIT_MODULE_ON 7
`define BIT_IRQ_ENABLE 6
`define BIT_OVF_FLAG 5
`define BIT_PIN_DRIVE 4
`define BIT_POLARITY 3
`define PRESCALE_HI 2
`define PRESCALE_LO 0

`define RST_CONTROL 8'h00
`define RST_PERIOD 8'h00
`define RST_DUTY 8'h00
`define RST_IRQ_MASK 1'b0
`define COUNT_RESTART 8'h01

`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// [rtl/single_8bit_pwm_control.v]
/*
  single-channel 8-bit pwm with control, period and duty registers behind an
  axi4-lite slave, sticky overflow interrupt with mask, and a pad output.
  assumes one clock aclk, synchronous active-low aresetn, and a master that
  follows axi4-lite handshakes; pwm_out goes straight to the port pad logic.
*/
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pwm_single_consts.vh"

module single_8bit_pwm_control #(
  parameter WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg pwm_out,
  output reg pwm_out_en,
  output wire irq
);

  reg module_on_r;
  reg overflow_irq_enable_r;
  reg overflow_flag_r;
  reg pin_drive_enable_r;
  reg polarity_select_r;
  reg [2:0] prescale_select_r;
  reg [WIDTH-1:0] period_value_r;
  reg [WIDTH-1:0] duty_value_r;
  reg [WIDTH-1:0] count_r;
  reg [6:0] prediv_r;
  reg irq_status_r;
  reg irq_mask_r;
  reg [7:0] aw_addr_r;
  reg aw_full_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_full_r;

  wire tick;
  wire ovf_event;
  wire active;
  wire wr_go;
  wire wr_ctrl;
  wire rd_go;
  wire [7:0] ctrl_byte;

  localparam [7:0] RST_CTRL = `RST_CONTROL;

  // mask of the low sel divider bits that must all be ones for a tick
  function [6:0] prescale_mask;
    input [2:0] sel;
    begin
      prescale_mask = (7'h01 << sel) - 7'h01;
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `OFS_CONTROL) || (addr == `OFS_PERIOD) || (addr == `OFS_DUTY) ||
               (addr == `OFS_COUNT) || (addr == `OFS_IRQ_STATUS) ||
               (addr == `OFS_IRQ_MASK);
    end
  endfunction

  // the divider free-runs while on, so a new prescale is used on the very next compare
  assign tick = module_on_r &&
                ((prediv_r & prescale_mask(prescale_select_r)) == prescale_mask(prescale_select_r));

  // count at or past the period on a tick: wrap to 1 and flag
  assign ovf_event = tick && (count_r >= period_value_r);

  // duty of zero never active; period at or below duty keeps the whole period active
  assign active = (duty_value_r != {WIDTH{1'b0}}) &&
                  ((period_value_r <= duty_value_r) || (count_r <= duty_value_r));

  assign ctrl_byte = {module_on_r, overflow_irq_enable_r, overflow_flag_r, pin_drive_enable_r,
                      polarity_select_r, prescale_select_r};

  // write address and data are taken independently; a full slot blocks its channel
  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready = !w_full_r;
  assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_ctrl = wr_go && (aw_addr_r == `OFS_CONTROL) && w_strb_r[0];
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;

  assign irq = (irq_status_r && irq_mask_r) || (overflow_flag_r && overflow_irq_enable_r);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_full_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_r) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      module_on_r <= RST_CTRL[`BIT_MODULE_ON];
      overflow_irq_enable_r <= RST_CTRL[`BIT_IRQ_ENABLE];
      pin_drive_enable_r <= RST_CTRL[`BIT_PIN_DRIVE];
      polarity_select_r <= RST_CTRL[`BIT_POLARITY];
      prescale_select_r <= RST_CTRL[`PRESCALE_HI:`PRESCALE_LO];
      period_value_r <= `RST_PERIOD;
      duty_value_r <= `RST_DUTY;
      irq_mask_r <= `RST_IRQ_MASK;
    end else if (wr_go && w_strb_r[0]) begin
      if (aw_addr_r == `OFS_CONTROL) begin
        module_on_r <= w_data_r[`BIT_MODULE_ON];
        overflow_irq_enable_r <= w_data_r[`BIT_IRQ_ENABLE];
        pin_drive_enable_r <= w_data_r[`BIT_PIN_DRIVE];
        polarity_select_r <= w_data_r[`BIT_POLARITY];
        prescale_select_r <= w_data_r[`PRESCALE_HI:`PRESCALE_LO];
      end
      if (aw_addr_r == `OFS_PERIOD)
        period_value_r <= w_data_r[WIDTH-1:0];
      if (aw_addr_r == `OFS_DUTY)
        duty_value_r <= w_data_r[WIDTH-1:0];
      if (aw_addr_r == `OFS_IRQ_MASK)
        irq_mask_r <= w_data_r[0];
    end
  end

  // counter and divider; turning on (off to on write) restarts both
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= `COUNT_RESTART;
      prediv_r <= 7'h00;
    end else if (wr_ctrl && w_data_r[`BIT_MODULE_ON] && !module_on_r) begin
      count_r <= `COUNT_RESTART;
      prediv_r <= 7'h00;
    end else if (!module_on_r) begin
      prediv_r <= 7'h00;
    end else begin
      prediv_r <= prediv_r + 7'h01;
      if (ovf_event)
        count_r <= `COUNT_RESTART;
      else if (tick)
        count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // hardware only sets; software clears the overflow flag by writing 0, the irq status by writing 1; a set in the same cycle wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag_r <= 1'b0;
      irq_status_r <= 1'b0;
    end else begin
      if (ovf_event)
        overflow_flag_r <= 1'b1;
      else if (wr_ctrl && !w_data_r[`BIT_OVF_FLAG])
        overflow_flag_r <= 1'b0;
      if (ovf_event)
        irq_status_r <= 1'b1;
      else if (wr_go && w_strb_r[0] && (aw_addr_r == `OFS_IRQ_STATUS) && w_data_r[0])
        irq_status_r <= 1'b0;
    end
  end

  // output registered one cycle after its cause; polarity and enable apply on that edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      pwm_out <= 1'b0;
      pwm_out_en <= 1'b0;
    end else begin
      pwm_out_en <= module_on_r && pin_drive_enable_r;
      if (module_on_r && pin_drive_enable_r)
        pwm_out <= active ^ polarity_select_r;
      else
        pwm_out <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      case (s_axi_araddr)
        `OFS_CONTROL: s_axi_rdata <= {24'h000000, ctrl_byte};
        `OFS_PERIOD: s_axi_rdata <= {24'h000000, period_value_r};
        `OFS_DUTY: s_axi_rdata <= {24'h000000, duty_value_r};
        `OFS_COUNT: s_axi_rdata <= {24'h000000, count_r};
        `OFS_IRQ_STATUS: s_axi_rdata <= {31'h00000000, irq_status_r};
        `OFS_IRQ_MASK: s_axi_rdata <= {31'h00000000, irq_mask_r};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // single_8bit_pwm_control

// [verification/pwm_port_props.sv]
/* port checker for the pwm block: bus holds, answers, pin gating.
   assumes one clock aclk and synchronous active-low aresetn. */
`timescale 1ns/1ps
module pwm_port_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire pwm_out,
  input wire pwm_out_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_pin_gated: assert property (!pwm_out_en |-> !pwm_out)
    else $error("waveform on undriven pin");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 ||
    s_axi_bresp == 2'b10) else $error("odd write response");
endmodule // pwm_port_checker

bind single_8bit_pwm_control pwm_port_checker u_pwm_port_checker (.*);

// [verification/test_single_8bit_pwm_control.sv]
/* self-checking bench for the pwm block: registers, waveform, irq.
   assumes the design and its constants header on the include path. */
`timescale 1ns/1ps
`include "pwm_single_consts.vh"
module test_single_8bit_pwm_control;
  reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, rdat;
  reg [3:0] wstrb;
  reg [1:0] rsp;
  reg [26:0] rows [0:4];
  wire awready, wready, bvalid, arready, rvalid, irq, pwm_out, pwm_out_en;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer num_errors, n_compared, i, hi;
  single_8bit_pwm_control u_single_8bit_pwm_control (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pwm_out(pwm_out), .pwm_out_en(pwm_out_en), .irq(irq));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task chk(input [95:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // each driving task (wr, rd) opens on a fresh edge so no signal is driven twice in one step
  task wr(input [7:0] a, input [7:0] d, input s);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= {3'b111, s};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      rsp = 2'b11;
      while (rsp === 2'b11) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          rsp = bresp;
          bready <= 1'b0;
        end
      end
      // registered outputs launched on this edge settle before the caller looks
      #1;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rsp = 2'b11;
      while (rsp === 2'b11) begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          rsp = rresp;
          rdat = rdata;
          rready <= 1'b0;
        end
      end
      #1;
    end
  endtask
  // settle for n cycles first: a prescale change may leave one odd tick gap
  task meas(input integer n);
    begin
      repeat (n) @(posedge aclk);
      hi = 0;
      repeat (n) begin
        @(posedge aclk);
        hi = hi + pwm_out;
      end
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    num_errors = num_errors + 1;
    complete_run;
  end
  initial begin
    num_errors = 0;
    n_compared = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    rows[0] = {1'b1, `OFS_PERIOD, 8'hAB, 8'hAB, `AXI_RESP_OKAY};
    rows[1] = {1'b1, `OFS_DUTY, 8'h5C, 8'h5C, `AXI_RESP_OKAY};
    rows[2] = {1'b0, `OFS_DUTY, 8'h11, 8'h5C, `AXI_RESP_OKAY};
    rows[3] = {1'b1, `OFS_COUNT, 8'h77, 8'h01, `AXI_RESP_OKAY};
    rows[4] = {1'b1, 8'h18, 8'hFF, 8'h00, `AXI_RESP_SLVERR};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_CONTROL);
    chk("control", rdat, 32'h0);
    chk("pin_en", pwm_out_en, 0);
    chk("irq", irq, 0);
    for (i = 0; i < 5; i = i + 1) begin
      wr(rows[i][25:18], rows[i][17:10], rows[i][26]);
      chk("bresp", rsp, rows[i][1:0]);
      rd(rows[i][25:18]);
      chk("rresp", rsp, rows[i][1:0]);
      chk("rdata", rdat, rows[i][9:2]);
    end
    $display("test registers done");
    wr(`OFS_PERIOD, 8'h04, 1'b1);
    wr(`OFS_DUTY, 8'h01, 1'b1);
    for (i = 0; i < 8; i = i + 1) begin
      wr(`OFS_CONTROL, {5'b10010, i[2:0]}, 1'b1);
      chk("pin_en", pwm_out_en, 1);
      meas(16 << i);
      chk("high_count", hi, 4 << i);
    end
    wr(`OFS_CONTROL, 8'h98, 1'b1);
    meas(16);
    chk("high_count", hi, 12);
    wr(`OFS_DUTY, 8'h05, 1'b1);
    meas(16);
    chk("high_count", hi, 0);
    wr(`OFS_DUTY, 8'h00, 1'b1);
    meas(16);
    chk("high_count", hi, 16);
    $display("test waveform done");
    wr(`OFS_CONTROL, 8'hE0, 1'b1);
    repeat (8) @(posedge aclk);
    chk("irq", irq, 1);
    chk("pin_en", pwm_out_en, 0);
    wr(`OFS_CONTROL, 8'h60, 1'b1);
    chk("irq", irq, 1);
    chk("pin_out", pwm_out, 0);
    wr(`OFS_CONTROL, 8'h40, 1'b1);
    chk("irq", irq, 0);
    repeat (40) @(posedge aclk);
    rd(`OFS_CONTROL);
    chk("control", rdat, 32'h40);
    wr(`OFS_IRQ_MASK, 8'h01, 1'b1);
    chk("irq", irq, 1);
    wr(`OFS_IRQ_STATUS, 8'h01, 1'b1);
    chk("irq", irq, 0);
    $display("test interrupt done");
    wr(`OFS_CONTROL, 8'h87, 1'b1);
    rd(`OFS_COUNT);
    chk("count", rdat, 32'h1);
    $display("test restart done");
    complete_run;
  end
endmodule // test_single_8bit_pwm_control
